// >>> mii_strap_pkg.sv
package mii_strap_pkg;

	// ------------------------------------------------------------
	// register map (word index, byte address is index * 4)
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_IRQ_CS_IDX   = 8'h1b; // irq enable / latched status
	localparam logic [7:0]  REG_PHY_CTRL_IDX = 8'h1f; // polarity, pin function, isolate
	localparam logic [7:0]  REG_STRAP_IDX    = 8'h20; // captured strap values, read only

	// control register fields
	localparam int          CTRL_WAKE_FLAG_BIT = 0;   // wake pending, write one to clear
	localparam int          CTRL_PIN_WAKE_BIT  = 8;   // 0: interrupt, 1: wake on the shared pin
	localparam int          CTRL_IRQ_POL_BIT   = 9;   // 0: active low, 1: active high
	localparam int          CTRL_ISOLATE_BIT   = 10;  // detach the mac-side outputs
	localparam logic [15:0] CTRL_WR_MASK       = 16'h0700;
	localparam logic [15:0] CTRL_RST_VAL       = 16'h0000;

	// irq control/status fields
	localparam int          IRQ_STAT_LSB   = 0;
	localparam int          IRQ_EN_LSB     = 8;
	localparam logic [7:0]  IRQ_EN_RST_VAL = 8'h00;

	// ------------------------------------------------------------
	// reset release and bus constants
	// ------------------------------------------------------------
	localparam logic [1:0]  STRAP_SETTLE_CYC = 2'h3;  // settle count at capture, reached after three settle cycles that follow the one reset-phase cycle
	localparam logic [2:0]  HSIZE_WORD       = 3'h2;
	localparam int          IDX_LSB          = 2;     // haddr bit of word index bit 0

	// ------------------------------------------------------------
	// synchronised pin inputs, bit positions in one vector
	// ------------------------------------------------------------
	localparam int          SI_RXD      = 0;          // four bits, receive nibble straps
	localparam int          SI_RX_VALID     = 4;
	localparam int          SI_RXC      = 5;
	localparam int          SI_RX_ERROR_OUT     = 6;
	localparam int          SI_IRQ      = 7;
	localparam int          SI_TXC      = 8;
	localparam int          SI_COL      = 9;
	localparam int          SI_CRS      = 10;
	localparam int          SI_TX_ENABLE_IN     = 11;
	localparam int          SI_TXD      = 12;         // four bits, transmit nibble
	localparam int          SI_MDC      = 16;
	localparam int          SI_MDIO     = 17;
	localparam int          SYNC_W      = 18;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		PH_RESET  = 3'h1,
		PH_SETTLE = 3'h2,
		PH_RUN    = 3'h4
	} phase_t;

	typedef struct packed
	{
		logic [2:0] mgmt_station_address;
		logic       duplex;
		logic [2:0] if_select;
		logic       bcast_addr_disable;
		logic       isolate;
		logic       test_tree_n;
		logic       wake_output_enable;
	} strap_t;

endpackage : mii_strap_pkg

// >>> sync_two_flop.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// two-flop synchroniser for a vector of independent levels
// ------------------------------------------------------------
module sync_two_flop
#(
	parameter int W = 1
)
(
	input  wire logic         clk_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	typedef struct packed
	{
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_st_t;

	sync_st_t q;
	sync_st_t d;

	// no reset: the chain must already track the pins while reset is held
	always_comb
	begin
		d        = q;
		d.meta   = async_i;
		d.stable = q.meta;
	end

	always_ff @(posedge clk_i)
	begin
		q <= d;
	end

	assign sync_o = q.stable;

endmodule : sync_two_flop

// >>> mii_pin_strap_config.sv
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps

// How it works
// RQ1 - at reset release, receive nibble pins 3,2,1 become station address bits 0,1,2
// RQ2 - at reset release, receive nibble pin 0 becomes the initial duplex setting
// RQ3 - at reset release, receive-valid pin becomes interface selector bit 2
// RQ4 - at reset release, receive-clock pin becomes the broadcast address disable
// RQ5 - at reset release, receive-error pin becomes the initial isolate setting
// RQ6 - at reset release, interrupt pin level selects test-tree mode, active low
// RQ7 - at reset release, transmit-clock pin becomes the wake output enable
// RQ8 - in normal operation drive receive nibble, valid, error and clock toward the mac
// RQ9 - in normal operation drive transmit clock and accept transmit enable from the mac
// RQ10 - board leaves the transmit-clock pin open in back-to-back repeater use
// RQ11 - programmable interrupt with enables and latched status at index 1bh
// RQ12 - bit 9 of index 1fh picks interrupt polarity, active low by default
// RQ13 - in wake function the shared pin is pulled low after a wake event
// RQ14 - interrupt/wake pin is open drain, never driven high
// RQ15 - management data is open drain; the device only pulls it low
// RQ16 - station manager supplies the management clock and times data to it
// RQ17 - system supplies a 25 mhz reference clock within 50 ppm
// RQ18 - at reset release, collision and carrier-sense pins become selector bits 0 and 1
// RQ19 - the mac drives the four transmit nibble inputs
// RQ20 - strap pins stay undriven while reset is held
module mii_pin_strap_config
(
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// ahb-lite register slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic      [31:0] hrdata_o,
	// shared strap / mii pins
	input  wire logic [3:0]  rx_nibble_pin_i,
	output logic      [3:0]  rx_nibble_pin_o,
	output logic      [3:0]  rx_nibble_oe_n_o,
	input  wire logic        rx_valid_pin_i,
	output logic             rx_valid_pin_o,
	output logic             rx_valid_oe_n_o,
	input  wire logic        rx_clk_out_pin_i,
	output logic             rx_clk_out_pin_o,
	output logic             rx_clk_out_oe_n_o,
	input  wire logic        rx_error_out_pin_i,
	output logic             rx_error_out_pin_o,
	output logic             rx_error_out_oe_n_o,
	input  wire logic        tx_clk_out_pin_i,
	output logic             tx_clk_out_pin_o,
	output logic             tx_clk_out_oe_n_o,
	input  wire logic        col_pin_i,
	output logic             col_pin_o,
	output logic             col_oe_n_o,
	input  wire logic        crs_pin_i,
	output logic             crs_pin_o,
	output logic             crs_oe_n_o,
	input  wire logic        irq_out_pin_i,
	output logic             irq_out_pin_o,
	output logic             irq_out_oe_n_o,
	input  wire logic        tx_enable_in_i,
	input  wire logic [3:0]  tx_nibble_i,
	input  wire logic        mdc_pin_i,
	input  wire logic        mdio_pin_i,
	output logic             mdio_pin_o,
	output logic             mdio_oe_n_o,
	// core side
	input  wire logic [3:0]  rx_nibble_i,
	input  wire logic        rx_valid_i,
	input  wire logic        rx_error_i,
	input  wire logic        rx_clk_i,
	input  wire logic        tx_clk_i,
	input  wire logic        col_i,
	input  wire logic        crs_i,
	input  wire logic [7:0]  irq_event_i,
	input  wire logic        wake_event_i,
	input  wire logic        mdio_pull_low_i,
	output logic             tx_enable_o,
	output logic      [3:0]  tx_nibble_o,
	output logic             mdio_bit_o,
	output logic             mdio_bit_valid_o,
	output logic      [2:0]  mgmt_station_address_o,
	output logic             duplex_o,
	output logic      [2:0]  if_select_o,
	output logic             bcast_addr_disable_o,
	output logic             isolate_o,
	output logic             test_tree_sel_o,
	output logic             wake_output_enable_o,
	output logic             strap_done_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed
	{
		mii_strap_pkg::phase_t phase;
		logic [1:0]            settle;
		logic                  strap_take;
		mii_strap_pkg::strap_t strap;
		logic [15:0]           ctrl;
		logic [7:0]            irq_stat;
		logic [7:0]            irq_en;
		logic                  ahb_wr;
		logic                  ahb_rd;
		logic [7:0]            ahb_idx;
		logic [31:0]           hrdata;
		logic [3:0]            rxd;
		logic                  rx_valid;
		logic                  rx_clk_out;
		logic                  rx_error_out;
		logic                  tx_clk_out;
		logic                  col;
		logic                  crs;
		logic                  mii_oe_n;
		logic                  irq_oe_n;
		logic                  mdio_oe_n;
		logic                  tx_en;
		logic [3:0]            txd;
		logic                  mdc_prev;
		logic                  mdio_bit;
		logic                  mdio_vld;
	} st_t;

	localparam st_t RST_VAL = '{
		phase:     mii_strap_pkg::PH_RESET,
		ctrl:      mii_strap_pkg::CTRL_RST_VAL,
		irq_en:    mii_strap_pkg::IRQ_EN_RST_VAL,
		mii_oe_n:  1'b1,
		irq_oe_n:  1'b1,
		mdio_oe_n: 1'b1,
		default:   '0
	};

	st_t                              q;
	st_t                              d;
	logic [mii_strap_pkg::SYNC_W-1:0] pin_raw;
	logic [mii_strap_pkg::SYNC_W-1:0] pin_s;
	logic                             take;
	logic                             pending;
	logic                             pin_low;
	logic                             wake_clr;
	logic                             running;

	// ------------------------------------------------------------
	// register read decode
	// ------------------------------------------------------------
	function automatic logic [31:0] reg_read(input st_t s, input logic [7:0] idx);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (idx)
			mii_strap_pkg::REG_IRQ_CS_IDX:   v = {16'h0000, s.irq_en, s.irq_stat};
			mii_strap_pkg::REG_PHY_CTRL_IDX:
			begin
				v                                   = {16'h0000, s.ctrl};
				v[mii_strap_pkg::CTRL_WAKE_FLAG_BIT] = s.ctrl[mii_strap_pkg::CTRL_WAKE_FLAG_BIT];
			end
			mii_strap_pkg::REG_STRAP_IDX:    v = {21'h0, s.strap};
			default:                         v = 32'h0000_0000; // unmapped reads zero
		endcase
		return v;
	endfunction : reg_read

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// every pin level is two flops away from any logic, straps included
	assign pin_raw = {mdio_pin_i, mdc_pin_i, tx_nibble_i, tx_enable_in_i, crs_pin_i, col_pin_i,
		tx_clk_out_pin_i, irq_out_pin_i, rx_error_out_pin_i, rx_clk_out_pin_i, rx_valid_pin_i,
		rx_nibble_pin_i};

	sync_two_flop
	#(
		.W (mii_strap_pkg::SYNC_W)
	)
	u_pin_sync
	(
		.clk_i   (clk_i),
		.async_i (pin_raw),
		.sync_o  (pin_s)
	);

	// ------------------------------------------------------------
	// helper terms
	// ------------------------------------------------------------
	assign running  = (q.phase == mii_strap_pkg::PH_RUN);
	assign take     = hsel_i && htrans_i[1] && hready_i && (hsize_i == mii_strap_pkg::HSIZE_WORD);
	assign pending  = |(q.irq_stat & q.irq_en);
	assign wake_clr = q.ahb_wr && (q.ahb_idx == mii_strap_pkg::REG_PHY_CTRL_IDX) &&
		hwdata_i[mii_strap_pkg::CTRL_WAKE_FLAG_BIT];

	// level the shared pin must show: low means pulled, high means released
	always_comb
	begin
		if (q.ctrl[mii_strap_pkg::CTRL_PIN_WAKE_BIT])
			pin_low = q.ctrl[mii_strap_pkg::CTRL_WAKE_FLAG_BIT] && q.strap.wake_output_enable; // RQ13
		else if (q.ctrl[mii_strap_pkg::CTRL_IRQ_POL_BIT])
			pin_low = !pending; // RQ12
		else
			pin_low = pending;  // RQ12
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		d            = q;
		d.strap_take = 1'b0;
		d.mdio_vld   = 1'b0;

		// reset release sequence; pins stay released until the run phase
		case (q.phase)
			mii_strap_pkg::PH_RESET:
			begin
				d.phase  = mii_strap_pkg::PH_SETTLE;
				d.settle = 2'h0;
			end
			mii_strap_pkg::PH_SETTLE:
			begin
				if (q.settle == mii_strap_pkg::STRAP_SETTLE_CYC)
				begin
					d.strap.mgmt_station_address = {pin_s[mii_strap_pkg::SI_RXD+1],
						pin_s[mii_strap_pkg::SI_RXD+2], pin_s[mii_strap_pkg::SI_RXD+3]}; // RQ1
					d.strap.duplex             = pin_s[mii_strap_pkg::SI_RXD];       // RQ2
					d.strap.if_select[2]       = pin_s[mii_strap_pkg::SI_RX_VALID];      // RQ3
					d.strap.if_select[1]       = pin_s[mii_strap_pkg::SI_CRS];       // RQ18
					d.strap.if_select[0]       = pin_s[mii_strap_pkg::SI_COL];       // RQ18
					d.strap.bcast_addr_disable = pin_s[mii_strap_pkg::SI_RXC];       // RQ4
					d.strap.isolate            = pin_s[mii_strap_pkg::SI_RX_ERROR_OUT];      // RQ5
					d.strap.test_tree_n        = pin_s[mii_strap_pkg::SI_IRQ];       // RQ6
					d.strap.wake_output_enable = pin_s[mii_strap_pkg::SI_TXC];       // RQ7
					d.ctrl[mii_strap_pkg::CTRL_ISOLATE_BIT] = pin_s[mii_strap_pkg::SI_RX_ERROR_OUT]; // RQ5
					d.strap_take = 1'b1;
					d.phase      = mii_strap_pkg::PH_RUN;
				end
				else
				begin
					d.settle = q.settle + 2'h1;
				end
			end
			mii_strap_pkg::PH_RUN:
			begin
				d.phase = mii_strap_pkg::PH_RUN;
			end
			default:
			begin
				d.phase = mii_strap_pkg::PH_RESET;
			end
		endcase

		// mac-side data always registered; isolate only releases the pins
		d.rxd      = rx_nibble_i; // RQ8
		d.rx_valid     = rx_valid_i;
		d.rx_error_out     = rx_error_i;
		d.rx_clk_out      = rx_clk_i;
		d.col      = col_i;
		d.crs      = crs_i;
		d.tx_clk_out      = tx_clk_i;    // RQ9
		d.mii_oe_n = !(running && !q.ctrl[mii_strap_pkg::CTRL_ISOLATE_BIT]); // RQ8 RQ20
		d.tx_en    = pin_s[mii_strap_pkg::SI_TX_ENABLE_IN]; // RQ9
		d.txd      = pin_s[mii_strap_pkg::SI_TXD +: 4];

		// open-drain shared pin: pull low or release, never drive high
		d.irq_oe_n  = !(running && pin_low);          // RQ14 RQ20
		d.mdio_oe_n = !(running && mdio_pull_low_i); // RQ15

		// management clock comes in as a plain sampled level
		d.mdc_prev = pin_s[mii_strap_pkg::SI_MDC];
		if (pin_s[mii_strap_pkg::SI_MDC] && !q.mdc_prev)
		begin
			d.mdio_bit = pin_s[mii_strap_pkg::SI_MDIO];
			d.mdio_vld = 1'b1;
		end

		// bus address phase; reads spend one wait cycle so data comes from a flop
		d.ahb_wr = take && hwrite_i;
		d.ahb_rd = take && !hwrite_i;
		if (take)
			d.ahb_idx = haddr_i[mii_strap_pkg::IDX_LSB +: 8];

		// bus data phase write
		if (q.ahb_wr && (q.ahb_idx == mii_strap_pkg::REG_PHY_CTRL_IDX))
			d.ctrl = (q.ctrl & ~mii_strap_pkg::CTRL_WR_MASK) |
				(hwdata_i[15:0] & mii_strap_pkg::CTRL_WR_MASK); // RQ12
		if (q.ahb_wr && (q.ahb_idx == mii_strap_pkg::REG_IRQ_CS_IDX))
			d.irq_en = hwdata_i[mii_strap_pkg::IRQ_EN_LSB +: 8]; // RQ11

		// bus data phase read; reading the irq word clears what it showed
		if (q.ahb_rd)
		begin
			d.hrdata = reg_read(q, q.ahb_idx);
			if (q.ahb_idx == mii_strap_pkg::REG_IRQ_CS_IDX)
				d.irq_stat = 8'h00; // RQ11
		end

		// events last so a set in the clearing cycle wins
		d.irq_stat = d.irq_stat | irq_event_i; // RQ11
		if (wake_clr)
			d.ctrl[mii_strap_pkg::CTRL_WAKE_FLAG_BIT] = 1'b0;
		if (wake_event_i)
			d.ctrl[mii_strap_pkg::CTRL_WAKE_FLAG_BIT] = 1'b1; // RQ13
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			q <= RST_VAL;
		else
			q <= d;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign hreadyout_o            = !q.ahb_rd;
	assign hresp_o                = 1'b0;
	assign hrdata_o               = q.hrdata;
	assign rx_nibble_pin_o        = q.rxd;
	assign rx_nibble_oe_n_o       = {4{q.mii_oe_n}};
	assign rx_valid_pin_o         = q.rx_valid;
	assign rx_valid_oe_n_o        = q.mii_oe_n;
	assign rx_clk_out_pin_o       = q.rx_clk_out;
	assign rx_clk_out_oe_n_o      = q.mii_oe_n;
	assign rx_error_out_pin_o     = q.rx_error_out;
	assign rx_error_out_oe_n_o    = q.mii_oe_n;
	assign tx_clk_out_pin_o       = q.tx_clk_out;
	assign tx_clk_out_oe_n_o      = q.mii_oe_n;
	assign col_pin_o              = q.col;
	assign col_oe_n_o             = q.mii_oe_n;
	assign crs_pin_o              = q.crs;
	assign crs_oe_n_o             = q.mii_oe_n;
	assign irq_out_pin_o          = 1'b0;
	assign irq_out_oe_n_o         = q.irq_oe_n;
	assign mdio_pin_o             = 1'b0;
	assign mdio_oe_n_o            = q.mdio_oe_n;
	assign tx_enable_o            = q.tx_en;
	assign tx_nibble_o            = q.txd;
	assign mdio_bit_o             = q.mdio_bit;
	assign mdio_bit_valid_o       = q.mdio_vld;
	assign mgmt_station_address_o = q.strap.mgmt_station_address;
	assign duplex_o               = q.strap.duplex;
	assign if_select_o            = q.strap.if_select;
	assign bcast_addr_disable_o   = q.strap.bcast_addr_disable;
	assign isolate_o              = q.ctrl[mii_strap_pkg::CTRL_ISOLATE_BIT];
	assign test_tree_sel_o        = !q.strap.test_tree_n;
	assign wake_output_enable_o   = q.strap.wake_output_enable;
	assign strap_done_o           = running;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_strap_pins_free: assert property (disable iff (1'b0) $past(!rstn_i) |-> // RQ20
		(&rx_nibble_oe_n_o && rx_valid_oe_n_o && rx_clk_out_oe_n_o && irq_out_oe_n_o))
		else $error("strap pin driven during reset");
	a_addr_capture: assert property (q.strap_take |-> mgmt_station_address_o == // RQ1
		{$past(pin_s[1], 1), $past(pin_s[2], 1), $past(pin_s[3], 1)})
		else $error("station address strap wrong");
	a_duplex_capture: assert property (q.strap_take |-> duplex_o == $past(pin_s[0])) // RQ2
		else $error("duplex strap wrong");
	a_sel_bit2_capture: assert property (q.strap_take |-> if_select_o[2] == $past(pin_s[4])) // RQ3
		else $error("selector bit 2 strap wrong");
	a_sel_low_capture: assert property (q.strap_take |-> // RQ18
		if_select_o[1:0] == {$past(pin_s[10]), $past(pin_s[9])})
		else $error("selector bits 1:0 strap wrong");
	a_bcast_capture: assert property (q.strap_take |-> bcast_addr_disable_o == $past(pin_s[5])) // RQ4
		else $error("broadcast disable strap wrong");
	a_isolate_capture: assert property (q.strap_take |=> isolate_o == $past(pin_s[6], 2)) // RQ5
		else $error("isolate strap wrong");
	a_test_tree_capture: assert property (q.strap_take |-> test_tree_sel_o == !$past(pin_s[7])) // RQ6
		else $error("test tree strap wrong");
	a_wake_en_capture: assert property (q.strap_take |-> wake_output_enable_o == $past(pin_s[8])) // RQ7
		else $error("wake enable strap wrong");
	a_rx_drive: assert property ((running && !isolate_o) ##1 (running && !isolate_o) |-> // RQ8
		(!rx_nibble_oe_n_o[0] && rx_nibble_pin_o == $past(rx_nibble_i) &&
		rx_valid_pin_o == $past(rx_valid_i)))
		else $error("receive outputs not driven");
	a_tx_path: assert property (running ##1 running |-> // RQ9
		(tx_enable_o == $past(pin_s[11]) && tx_clk_out_pin_o == $past(tx_clk_i)))
		else $error("transmit path wrong");
	a_irq_low_pol: assert property (running && !q.ctrl[8] && !q.ctrl[9] && pending |=> // RQ12
		!irq_out_oe_n_o)
		else $error("active-low interrupt not pulled");
	a_irq_high_pol: assert property (running && !q.ctrl[8] && q.ctrl[9] && pending |=> // RQ12
		irq_out_oe_n_o)
		else $error("active-high interrupt not released");
	a_irq_read_clear: assert property (q.ahb_rd && q.ahb_idx == 8'h1b && irq_event_i == 8'h00 |=> // RQ11
		(q.irq_stat == 8'h00 && hrdata_o[7:0] == $past(q.irq_stat)))
		else $error("interrupt status read or clear wrong");
	a_wake_pull: assert property (running && q.ctrl[8] && q.ctrl[0] && q.strap.wake_output_enable
		|=> !irq_out_oe_n_o) // RQ13
		else $error("wake event not signalled");
	a_irq_open_drain: assert property (!irq_out_oe_n_o |-> !irq_out_pin_o && $past(running)) // RQ14
		else $error("interrupt pin driven high");
	a_mdio_open_drain: assert property (mdio_oe_n_o == !($past(running) && $past(mdio_pull_low_i)) // RQ15
		&& !mdio_pin_o)
		else $error("management data drive wrong");

endmodule : mii_pin_strap_config

// >>> mii_mac_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// mac and board side: pull resistors, pin wires, mac drive, host
// ------------------------------------------------------------
module mii_mac_model
(
	input  wire logic        clk_i,
	input  wire logic [10:0] pull_i,
	input  wire logic [10:0] pin_o_i,
	input  wire logic [10:0] oe_n_i,
	input  wire logic        mdio_oe_n_i,
	output logic      [10:0] wire_o,
	output logic             mdc_o,
	output logic             mdio_o,
	output logic             tx_en_o,
	output logic      [3:0]  tx_nib_o
);
	logic host_low; // host side pulls mdio low

	// a released pin falls to its board pull, so straps see only resistors
	// tx clock pin is wired like the others here, pull when released, driven otherwise; repeater boards leave it open
	assign wire_o = (pull_i & oe_n_i) | (pin_o_i & ~oe_n_i);
	// open drain from both sides, the pull-up alone makes a one
	assign mdio_o = ~(~mdio_oe_n_i | host_low);

	// mdc stands low between frames
	initial
	begin
		mdc_o    = 1'b0;
		host_low = 1'b0;
		tx_en_o  = 1'b0;
		tx_nib_o = 4'h0;
	end

	// mac launches the transmit nibble just after the clock edge
	task automatic mac_tx(input logic en, input logic [3:0] nib);
		@(posedge clk_i);
		tx_en_o  <= en;
		tx_nib_o <= nib;
	endtask : mac_tx

	// one management bit, data set up half a period before mdc rises
	task automatic mgmt_bit(input logic b);
		host_low = ~b;
		#40 mdc_o = 1'b1;
		#40 mdc_o = 1'b0;
		host_low = 1'b0;
	endtask : mgmt_bit
endmodule : mii_mac_model

// >>> mii_pin_strap_config_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end

// ------------------------------------------------------------
// bench: straps over two resets, mii pins, management, irq
// ------------------------------------------------------------
module mii_pin_strap_config_tb_top;
	logic        clk_i = 1'b0;
	logic        rstn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, mdio_pin_o, mdio_oe_n_o;
	logic        wake_event_i, mdio_pull_low_i, tx_enable_o, mdio_bit_o, mdio_bit_valid_o;
	logic        mdc, mdio_w, tx_en;
	logic [1:0]  htrans_i;
	logic [2:0]  hsize_i;
	logic [3:0]  tx_nibble_o, tx_nib;
	logic [7:0]  irq_event_i;
	logic [10:0] po, oe, w, pull, cv;
	logic [11:0] st;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
	int          error_cnt = 0;
	int          n_checks = 0;

	always #4 clk_i = ~clk_i;

	mii_pin_strap_config dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .hrdata_o(hrdata_o), .rx_nibble_pin_i(w[3:0]),
		.rx_nibble_pin_o(po[3:0]), .rx_nibble_oe_n_o(oe[3:0]), .rx_valid_pin_i(w[4]),
		.rx_valid_pin_o(po[4]), .rx_valid_oe_n_o(oe[4]), .rx_clk_out_pin_i(w[5]),
		.rx_clk_out_pin_o(po[5]), .rx_clk_out_oe_n_o(oe[5]), .rx_error_out_pin_i(w[6]),
		.rx_error_out_pin_o(po[6]), .rx_error_out_oe_n_o(oe[6]), .irq_out_pin_i(w[7]),
		.irq_out_pin_o(po[7]), .irq_out_oe_n_o(oe[7]), .tx_clk_out_pin_i(w[8]),
		.tx_clk_out_pin_o(po[8]), .tx_clk_out_oe_n_o(oe[8]), .col_pin_i(w[9]),
		.col_pin_o(po[9]), .col_oe_n_o(oe[9]), .crs_pin_i(w[10]), .crs_pin_o(po[10]),
		.crs_oe_n_o(oe[10]), .tx_enable_in_i(tx_en), .tx_nibble_i(tx_nib),
		.mdc_pin_i(mdc), .mdio_pin_i(mdio_w), .mdio_pin_o(mdio_pin_o),
		.mdio_oe_n_o(mdio_oe_n_o), .rx_nibble_i(cv[3:0]), .rx_valid_i(cv[4]),
		.rx_clk_i(cv[5]), .rx_error_i(cv[6]), .tx_clk_i(cv[8]), .col_i(cv[9]),
		.crs_i(cv[10]), .irq_event_i(irq_event_i), .wake_event_i(wake_event_i),
		.mdio_pull_low_i(mdio_pull_low_i), .tx_enable_o(tx_enable_o),
		.tx_nibble_o(tx_nibble_o), .mdio_bit_o(mdio_bit_o),
		.mdio_bit_valid_o(mdio_bit_valid_o), .mgmt_station_address_o(st[11:9]),
		.duplex_o(st[8]), .if_select_o(st[7:5]), .bcast_addr_disable_o(st[4]),
		.isolate_o(st[3]), .test_tree_sel_o(st[2]), .wake_output_enable_o(st[1]),
		.strap_done_o(st[0]));

	mii_mac_model model_u (.clk_i(clk_i), .pull_i(pull), .pin_o_i(po), .oe_n_i(oe),
		.mdio_oe_n_i(mdio_oe_n_o), .wire_o(w), .mdc_o(mdc), .mdio_o(mdio_w),
		.tx_en_o(tx_en), .tx_nib_o(tx_nib));

	// expected straps: address bit 0 from nibble pin 3, selector {valid, crs, col}
	function automatic logic [11:0] strap_exp(input logic [10:0] p);
		strap_exp = {p[1], p[2], p[3], p[0], p[4], p[10], p[9], p[5], p[6], ~p[7], p[8], 1'b1};
	endfunction : strap_exp

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	// single ahb-lite word transfer, each phase held until hready is seen high
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel_i   <= 1'b1;
		haddr_i  <= a;
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		q = hrdata_o;
		`CHK(hresp_o, 1'b0)
	endtask : ahb

	task automatic pulse(input logic [8:0] v);
		@(posedge clk_i);
		{wake_event_i, irq_event_i} <= v;
		@(posedge clk_i);
		{wake_event_i, irq_event_i} <= 9'h000;
	endtask : pulse

	// straps must read back from resistors alone, in every reset
	task automatic do_reset(input logic [10:0] p);
		logic [11:0] e;
		e = strap_exp(p);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		pull   <= p;
		tick(20);
		`CHK({oe, st[0]}, 12'hffe)
		@(posedge clk_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 20 && st[0] !== 1'b1; i++) @(posedge clk_i);
		#1 `CHK(st, e)
		ahb(1'b0, 32'h0000_0080, 32'h0);
		`CHK(q, {21'h0, e[11:3], ~e[2], e[1]})
		tick(2);
	endtask : do_reset

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	initial
	begin
		#100000;
		error_cnt++;
		test_done();
	end

	// main sequence
	initial
	begin
		{rstn_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
		{wake_event_i, irq_event_i, mdio_pull_low_i, cv} = '0;
		hsize_i = 3'h2;
		pull    = 11'h35c;
		do_reset(11'h35c);
		`CHK(oe & 11'h77f, 11'h77f)
		ahb(1'b1, 32'h0000_007c, 32'h0000_0100);
		tick(2);
		`CHK(oe & 11'h77f, 11'h000)
		pulse(9'h100);
		tick(2);
		`CHK({oe[7], po[7]}, 2'b00)
		ahb(1'b0, 32'h0000_007c, 32'h0);
		`CHK(q, 32'h0000_0101)
		ahb(1'b1, 32'h0000_007c, 32'h0000_0101);
		tick(2);
		`CHK(oe[7], 1'b1)
		do_reset(11'h4a3);
		foreach (pull[k])
		begin
			@(posedge clk_i);
			cv <= 11'h36a ^ (11'h7ff >> k);
			tick(1);
			`CHK(w & 11'h77f, (11'h36a ^ (11'h7ff >> k)) & 11'h77f)
		end
		model_u.mac_tx(1'b1, 4'h9);
		tick(3);
		`CHK({tx_enable_o, tx_nibble_o}, 5'h19)
		model_u.mac_tx(1'b0, 4'h6);
		tick(3);
		`CHK({tx_enable_o, tx_nibble_o}, 5'h06)
		for (int b = 0; b < 2; b++)
		begin
			// the valid pulse stands one cycle, so look at it mid-cycle while it stands
			fork
				model_u.mgmt_bit(b[0]);
				begin
					for (int i = 0; i < 20 && mdio_bit_valid_o !== 1'b1; i++) @(negedge clk_i);
					`CHK({mdio_bit_valid_o, mdio_bit_o}, {1'b1, b[0]})
				end
			join
		end
		for (int b = 0; b < 2; b++)
		begin
			@(posedge clk_i);
			mdio_pull_low_i <= ~b[0];
			tick(2);
			`CHK({mdio_oe_n_o, mdio_pin_o, mdio_w}, {b[0], 1'b0, b[0]})
		end
		ahb(1'b1, 32'h0000_006c, 32'h0000_0200);
		pulse(9'h001);
		tick(2);
		`CHK(oe[7], 1'b1)
		ahb(1'b0, 32'h0000_006c, 32'h0);
		`CHK(q, 32'h0000_0201)
		ahb(1'b0, 32'h0000_006c, 32'h0);
		`CHK(q, 32'h0000_0200)
		pulse(9'h002);
		tick(2);
		`CHK({oe[7], po[7]}, 2'b00)
		ahb(1'b1, 32'h0000_007c, 32'h0000_0200);
		tick(2);
		`CHK(oe[7], 1'b1)
		ahb(1'b0, 32'h0000_006c, 32'h0);
		tick(2);
		`CHK(oe[7], 1'b0)
		ahb(1'b0, 32'h0000_0040, 32'h0);
		`CHK(q, 32'h0000_0000)
		test_done();
	end
endmodule : mii_pin_strap_config_tb_top
